/* File: design/frame_fifo_defines.svh */
/*
  Register offsets, field positions, reset values and TRS codes of the frame FIFO.
  Included by every design file that decodes registers or video words.
*/
`ifndef FRAME_FIFO_DEFINES_SVH
`define FRAME_FIFO_DEFINES_SVH

// Byte offsets on the register bus
`define CTRL_OFS 8'h00
`define AE_THR_OFS 8'h04
`define AF_THR_OFS 8'h08
`define LINE_LEN_OFS 8'h0c
`define STATUS_OFS 8'h10
`define WPTR_OFS 8'h14
`define RPTR_OFS 8'h18

// Control register fields
`define CTRL_2D_BIT 0
`define CTRL_TRS_F_BIT 1
`define CTRL_TRS_V_BIT 2
`define CTRL_RESET 3'h0

// Threshold reset fractions of the channel depth
`define THR_DEN 80
`define AE_NUM 1
`define AF_NUM 79

// Timing reference words, top byte of the lane
`define TRS_PRE 8'hff
`define TRS_ZERO 8'h00
`define TRS_F_BIT 6
`define TRS_V_BIT 5

`endif

/* File: design/frame_fifo_pkg.sv */
/*
  Types shared by the frame FIFO design files.
  Assumes nothing of its surroundings.
*/
package frame_fifo_pkg;
  typedef enum logic {BUS_IDLE = 1'b0, BUS_ACK = 1'b1} bus_state_t;
  typedef enum logic [1:0] {LANE_8 = 2'b00, LANE_10 = 2'b01, LANE_12 = 2'b11} lane_width_t;
endpackage

/* File: design/fifo_channel.sv */
/*
  One FIFO channel: word memory, write and read pointers, TRS watch and level flags.
  Assumes every control input is synchronous to clk and already decoded by the top level.
*/
`include "frame_fifo_defines.svh"

module fifo_channel
  import frame_fifo_pkg::*;
#(
  parameter int DEPTH = 160,
  parameter int DW = 12
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Write side
  input wire logic wr_en_n,
  input wire logic wr_clr_n,
  input wire logic wr_load,
  input wire logic [DW-1:0] wr_data,
  input wire logic trs_f_en,
  input wire logic trs_v_en,
  // Read side
  input wire logic rd_en_n,
  input wire logic rd_clr_n,
  input wire logic rd_load,
  // Shared address and thresholds
  input wire logic [23:0] ext_addr,
  input wire logic [23:0] ae_thr,
  input wire logic [23:0] af_thr,
  // Results
  output logic [DW-1:0] rd_data,
  output logic [23:0] wr_ptr,
  output logic [23:0] rd_ptr,
  output logic trs_hit,
  output logic collide,
  output logic almost_empty,
  output logic almost_full
);
  localparam int IW = $clog2(DEPTH);
  localparam logic [23:0] LAST = 24'(DEPTH - 1);
  localparam logic [23:0] SPAN = 24'(DEPTH);

  logic [DW-1:0] mem [DEPTH];
  logic [23:0] wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
  logic [DW-1:0] rd_data_reg;
  logic [7:0] hist1_reg, hist2_reg, hist3_reg;
  logic sync_bit_reg, collide_reg, empty_reg, full_reg;

  function automatic logic [23:0] step(input logic [23:0] a);
    return (a >= LAST) ? 24'h000000 : a + 24'h000001; // RULE23
  endfunction

  // Clear beats load so a frame start always lands on word zero
  wire [23:0] wr_addr = !wr_clr_n ? 24'h000000 : (wr_load ? ext_addr : wr_ptr_reg); // RULE4
  wire [23:0] rd_addr = !rd_clr_n ? 24'h000000 : (rd_load ? ext_addr : rd_ptr_reg); // RULE5
  wire wr_fire = !wr_en_n && (wr_addr <= LAST);
  wire rd_fire = !rd_en_n && (rd_addr <= LAST);

  wire [7:0] top_byte = wr_data[DW-1 -: 8];
  wire trs_word = !wr_en_n && hist3_reg == `TRS_PRE && hist2_reg == `TRS_ZERO && hist1_reg == `TRS_ZERO;
  wire sync_bit = (trs_f_en && top_byte[`TRS_F_BIT]) || (trs_v_en && top_byte[`TRS_V_BIT]);
  // Clearing on the falling edge of F or V points word zero at the first active line
  assign trs_hit = trs_word && sync_bit_reg && !sync_bit; // RULE12

  assign wr_ptr_next = trs_hit ? 24'h000000 : (!wr_en_n ? step(wr_addr) : wr_addr); // RULE6 RULE10
  assign rd_ptr_next = !rd_en_n ? step(rd_addr) : rd_addr; // RULE6 RULE10
  wire [23:0] fill = (wr_ptr_reg >= rd_ptr_reg) ? wr_ptr_reg - rd_ptr_reg : wr_ptr_reg + SPAN - rd_ptr_reg;

  // Memory has no reset; reads never disturb it
  always_ff @(posedge clk) begin
    if (wr_fire) begin
      mem[wr_addr[IW-1:0]] <= wr_data; // RULE19
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr_reg <= 24'h000000;
      rd_ptr_reg <= 24'h000000;
      rd_data_reg <= '0;
      hist1_reg <= 8'h00;
      hist2_reg <= 8'h00;
      hist3_reg <= 8'h00;
      sync_bit_reg <= 1'b0;
      collide_reg <= 1'b0;
      empty_reg <= 1'b0;
      full_reg <= 1'b0;
    end else begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      if (rd_fire) begin
        rd_data_reg <= mem[rd_addr[IW-1:0]]; // RULE18 RULE19
      end
      if (!wr_en_n) begin
        hist1_reg <= top_byte;
        hist2_reg <= hist1_reg;
        hist3_reg <= hist2_reg;
      end
      if (trs_word) begin
        sync_bit_reg <= sync_bit;
      end
      collide_reg <= wr_ptr_reg == rd_ptr_reg; // RULE13
      empty_reg <= fill < ae_thr; // RULE15
      full_reg <= fill >= af_thr; // RULE16
    end
  end

  assign rd_data = rd_data_reg;
  assign wr_ptr = wr_ptr_reg;
  assign rd_ptr = rd_ptr_reg;
  assign collide = collide_reg;
  assign almost_empty = empty_reg;
  assign almost_full = full_reg;

  a_trs_clear_ptr: assert property (@(posedge clk) disable iff (!rst_b) // RULE12
    trs_hit |=> wr_ptr_reg == 24'h000000)
    else $error("TRS hit did not clear the write pointer");

  c_trs_hit: cover property (@(posedge clk) disable iff (!rst_b) trs_hit);
endmodule

/* File: design/video_frame_fifo_pointer_ctrl.sv */
/*
  Frame FIFO top: organisation decode, external address routing, 2-D mapping,
  configuration registers on an Avalon-MM slave, and two channel instances.
  Assumes every pin is driven by logic on clk and that organisation pins are static.
*/
// Summary of operation
// RULE1: Top bit zero selects one channel
// RULE2: Code 11xx gives two channels, shared clock
// RULE3: External address ignored in dual mode
// RULE4: Write clear low zeroes write pointer
// RULE5: Read clear low zeroes read pointer
// RULE6: Enables low store or fetch, advance
// RULE7: 24-bit external address reaches every word
// RULE8: Write load plus side zero loads write
// RULE9: Read load plus side one loads read
// RULE10: After override, counting resumes from there
// RULE11: 2-D mode splits address row, column
// RULE12: TRS F or V clears write pointer
// RULE13: Collision flag high when pointers meet
// RULE14: Programmable thresholds, reset 1/80 and 79/80
// RULE15: Almost empty when fill below threshold
// RULE16: Almost full when lead within margin
// RULE17: Static pins plus programmable configuration words
// RULE18: Reads never disturb stored words
// RULE19: Writes and reads run independently
// RULE20: Address space wide enough for cascading
// RULE21: Organisation code sets word width
// RULE22: Side select zero write, one read
// RULE23: Sequential pointers wrap after last word
`include "frame_fifo_defines.svh"

module video_frame_fifo_pointer_ctrl
  import frame_fifo_pkg::*;
#(
  parameter int CH_DEPTH = 160,
  parameter logic [11:0] LINE_LEN_RESET = 12'h010
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Avalon-MM slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Organisation tie-offs
  input wire logic [3:0] org_select,
  // Write ports
  input wire logic [1:0] write_enable_n,
  input wire logic [1:0] write_pointer_clear_n,
  input wire logic write_address_load_n,
  input wire logic [11:0] channel_zero_data_in,
  input wire logic [11:0] channel_one_data_in,
  // Read ports
  input wire logic [1:0] read_enable_n,
  input wire logic [1:0] read_pointer_clear_n,
  input wire logic read_address_load_n,
  // External address port
  input wire logic [23:0] ext_address,
  input wire logic ext_port_side_select,
  // Data and flags
  output logic [11:0] channel_zero_data_out,
  output logic [11:0] channel_one_data_out,
  output logic [1:0] pointer_collision_flag,
  output logic [1:0] almost_empty_flag,
  output logic [1:0] almost_full_flag
);
  localparam logic [23:0] AE_RESET = 24'(CH_DEPTH * `AE_NUM / `THR_DEN); // RULE14
  localparam logic [23:0] AF_RESET = 24'(CH_DEPTH * `AF_NUM / `THR_DEN); // RULE14

  bus_state_t state_reg, state_next;
  logic waitrequest_reg, waitrequest_next;
  logic [31:0] readdata_reg;
  logic [2:0] ctrl_reg;
  logic [23:0] ae_thr_reg, af_thr_reg;
  logic [11:0] line_len_reg;
  logic [23:0] wptr0, rptr0;
  logic trs_hit0;

  function automatic lane_width_t lane_code(input logic [1:0] code);
    if (!code[1]) begin
      return LANE_8;
    end else if (!code[0]) begin
      return LANE_10;
    end
    return LANE_12;
  endfunction

  // Lanes are left aligned, so narrow words drop the low bits
  function automatic logic [11:0] lane_mask(input lane_width_t w);
    case (w)
      LANE_8: return 12'hff0;
      LANE_10: return 12'hffc;
      default: return 12'hfff;
    endcase
  endfunction

  function automatic logic [23:0] map_2d(input logic [23:0] a, input logic [11:0] len);
    return 24'(a[23:12]) * 24'(len) + {12'h000, a[11:0]};
  endfunction

  function automatic logic [31:0] merge_be(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[8*i +: 8] = wd[8*i +: 8];
      end
    end
    return res;
  endfunction

  // Organisation decode
  wire dual = org_select[3] && org_select[2]; // RULE2
  wire wide = org_select[3] && !org_select[2]; // RULE1
  wire [11:0] lane = lane_mask(lane_code(org_select[1:0])); // RULE21
  wire [11:0] d0_in = channel_zero_data_in & lane; // RULE21
  wire [11:0] d1_in = (dual || wide) ? (channel_one_data_in & lane) : 12'h000; // RULE21

  // External address routing; dual mode has no override at all
  wire wr_load = !dual && !write_address_load_n && !ext_port_side_select; // RULE3 RULE8 RULE22
  wire rd_load = !dual && !read_address_load_n && ext_port_side_select; // RULE3 RULE9 RULE22
  wire [23:0] mapped_addr = ctrl_reg[`CTRL_2D_BIT] ? map_2d(ext_address, line_len_reg) : ext_address; // RULE7 RULE11

  // Channel one follows channel zero controls unless the device is split
  wire ch1_wr_en_n = dual ? write_enable_n[1] : write_enable_n[0]; // RULE1 RULE2
  wire ch1_wr_clr_n = dual ? write_pointer_clear_n[1] : write_pointer_clear_n[0];
  wire ch1_rd_en_n = dual ? read_enable_n[1] : read_enable_n[0];
  wire ch1_rd_clr_n = dual ? read_pointer_clear_n[1] : read_pointer_clear_n[0];

  // Register bus decode
  wire bus_req = avs_read || avs_write;
  wire bus_take = state_reg == BUS_IDLE && bus_req;
  wire bus_commit = state_reg == BUS_ACK && avs_write;
  wire hit_ctrl = avs_address == `CTRL_OFS;
  wire hit_ae = avs_address == `AE_THR_OFS;
  wire hit_af = avs_address == `AF_THR_OFS;
  wire hit_len = avs_address == `LINE_LEN_OFS;
  wire hit_status = avs_address == `STATUS_OFS;
  wire hit_wptr = avs_address == `WPTR_OFS;
  wire hit_rptr = avs_address == `RPTR_OFS;
  wire [31:0] wr_ctrl = merge_be({29'h0, ctrl_reg}, avs_writedata, avs_byteenable);
  wire [31:0] wr_ae = merge_be({8'h00, ae_thr_reg}, avs_writedata, avs_byteenable);
  wire [31:0] wr_af = merge_be({8'h00, af_thr_reg}, avs_writedata, avs_byteenable);
  wire [31:0] wr_len = merge_be({20'h0, line_len_reg}, avs_writedata, avs_byteenable);
  wire [31:0] status_word = {25'h0, dual, almost_full_flag, almost_empty_flag, pointer_collision_flag};
  // Unmapped offsets read as zero and ignore writes
  wire [31:0] read_word = hit_ctrl ? {29'h0, ctrl_reg} :
                          hit_ae ? {8'h00, ae_thr_reg} :
                          hit_af ? {8'h00, af_thr_reg} :
                          hit_len ? {20'h0, line_len_reg} :
                          hit_status ? status_word :
                          hit_wptr ? {8'h00, wptr0} :
                          hit_rptr ? {8'h00, rptr0} : 32'h00000000;

  always_comb begin
    case (state_reg)
      BUS_IDLE: state_next = bus_req ? BUS_ACK : BUS_IDLE;
      BUS_ACK: state_next = BUS_IDLE;
      default: state_next = BUS_IDLE;
    endcase
  end

  assign waitrequest_next = state_next != BUS_ACK;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= BUS_IDLE;
      waitrequest_reg <= 1'b1;
      readdata_reg <= 32'h00000000;
    end else begin
      state_reg <= state_next;
      waitrequest_reg <= waitrequest_next;
      if (bus_take && avs_read) begin
        readdata_reg <= read_word;
      end
    end
  end

  // Configuration words replace the serial port of the original device
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_reg <= `CTRL_RESET;
      ae_thr_reg <= AE_RESET; // RULE14
      af_thr_reg <= AF_RESET; // RULE14
      line_len_reg <= LINE_LEN_RESET;
    end else if (bus_commit) begin
      if (hit_ctrl) begin
        ctrl_reg <= wr_ctrl[2:0]; // RULE17
      end
      if (hit_ae) begin
        ae_thr_reg <= wr_ae[23:0]; // RULE14
      end
      if (hit_af) begin
        af_thr_reg <= wr_af[23:0]; // RULE14
      end
      if (hit_len) begin
        line_len_reg <= wr_len[11:0]; // RULE11
      end
    end
  end

  assign avs_waitrequest = waitrequest_reg;
  assign avs_readdata = readdata_reg;

  // 24-bit pointers leave room for a continuous cascaded address space
  fifo_channel #(.DEPTH(CH_DEPTH), .DW(12)) u_ch0 ( // RULE20
    .clk(clk),
    .rst_b(rst_b),
    .wr_en_n(write_enable_n[0]),
    .wr_clr_n(write_pointer_clear_n[0]),
    .wr_load(wr_load),
    .wr_data(d0_in),
    .trs_f_en(ctrl_reg[`CTRL_TRS_F_BIT]),
    .trs_v_en(ctrl_reg[`CTRL_TRS_V_BIT]),
    .rd_en_n(read_enable_n[0]),
    .rd_clr_n(read_pointer_clear_n[0]),
    .rd_load(rd_load),
    .ext_addr(mapped_addr),
    .ae_thr(ae_thr_reg),
    .af_thr(af_thr_reg),
    .rd_data(channel_zero_data_out),
    .wr_ptr(wptr0),
    .rd_ptr(rptr0),
    .trs_hit(trs_hit0),
    .collide(pointer_collision_flag[0]),
    .almost_empty(almost_empty_flag[0]),
    .almost_full(almost_full_flag[0])
  );

  fifo_channel #(.DEPTH(CH_DEPTH), .DW(12)) u_ch1 (
    .clk(clk),
    .rst_b(rst_b),
    .wr_en_n(ch1_wr_en_n),
    .wr_clr_n(ch1_wr_clr_n),
    .wr_load(wr_load),
    .wr_data(d1_in),
    .trs_f_en(ctrl_reg[`CTRL_TRS_F_BIT]),
    .trs_v_en(ctrl_reg[`CTRL_TRS_V_BIT]),
    .rd_en_n(ch1_rd_en_n),
    .rd_clr_n(ch1_rd_clr_n),
    .rd_load(rd_load),
    .ext_addr(mapped_addr),
    .ae_thr(ae_thr_reg),
    .af_thr(af_thr_reg),
    .rd_data(channel_one_data_out),
    .wr_ptr(),
    .rd_ptr(),
    .trs_hit(),
    .collide(pointer_collision_flag[1]),
    .almost_empty(almost_empty_flag[1]),
    .almost_full(almost_full_flag[1])
  );

  localparam logic [23:0] LAST = 24'(CH_DEPTH - 1);
  // Fill of channel zero, worked out apart from the channel to cross-check its flags
  wire [23:0] fill0 = (wptr0 >= rptr0) ? wptr0 - rptr0 : wptr0 + 24'(CH_DEPTH) - rptr0;

  a_bus_one_wait: assert property (@(posedge clk) disable iff (!rst_b)
    bus_req && avs_waitrequest && state_reg == BUS_IDLE |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("Bus answer not given after exactly one wait cycle");

  a_write_clear_zero: assert property (@(posedge clk) disable iff (!rst_b) // RULE4
    !write_pointer_clear_n[0] && !trs_hit0 |=> wptr0 == (write_enable_n[0] ? 24'h000000 : 24'h000001))
    else $error("Write clear did not restart at word zero");

  a_read_clear_zero: assert property (@(posedge clk) disable iff (!rst_b) // RULE5
    !read_pointer_clear_n[0] && read_enable_n[0] |=> rptr0 == 24'h000000)
    else $error("Read clear did not zero the read pointer");

  a_write_step_one: assert property (@(posedge clk) disable iff (!rst_b) // RULE6
    !write_enable_n[0] && write_pointer_clear_n[0] && !wr_load && !trs_hit0 && wptr0 < LAST
    |=> wptr0 == $past(wptr0) + 24'h000001)
    else $error("Write pointer did not advance by one");

  a_read_idle_hold: assert property (@(posedge clk) disable iff (!rst_b) // RULE18
    read_enable_n[0] && read_pointer_clear_n[0] && !rd_load |=> $stable(rptr0) && $stable(channel_zero_data_out))
    else $error("Read side moved while idle");

  a_dual_no_override: assert property (@(posedge clk) disable iff (!rst_b) // RULE3
    dual |-> !wr_load && !rd_load)
    else $error("External address used in dual mode");

  a_read_load_resume: assert property (@(posedge clk) disable iff (!rst_b) // RULE9
    rd_load && read_pointer_clear_n[0] && !read_enable_n[0] && mapped_addr < LAST
    |=> rptr0 == $past(mapped_addr) + 24'h000001)
    else $error("Read pointer did not resume after the loaded address");

  a_write_load_side: assert property (@(posedge clk) disable iff (!rst_b) // RULE8
    wr_load && write_pointer_clear_n[0] && write_enable_n[0] && !trs_hit0 |=> wptr0 == $past(mapped_addr))
    else $error("Write pointer did not take the external address");

  a_write_wrap_zero: assert property (@(posedge clk) disable iff (!rst_b) // RULE23
    !write_enable_n[0] && write_pointer_clear_n[0] && !wr_load && wptr0 == LAST |=> wptr0 == 24'h000000)
    else $error("Write pointer did not wrap at the last word");

  a_collide_meet: assert property (@(posedge clk) disable iff (!rst_b) // RULE13
    rst_b && wptr0 == rptr0 |=> pointer_collision_flag[0])
    else $error("Collision flag missing when pointers met");

  a_thr_write: assert property (@(posedge clk) disable iff (!rst_b) // RULE14
    bus_commit && hit_ae && (&avs_byteenable[2:0]) |=> ae_thr_reg == $past(avs_writedata[23:0]))
    else $error("Almost-empty threshold not written");

  a_collide_apart: assert property (@(posedge clk) disable iff (!rst_b) // RULE13
    rst_b && wptr0 != rptr0 |=> !pointer_collision_flag[0])
    else $error("Collision flag high while pointers apart");

  a_empty_set: assert property (@(posedge clk) disable iff (!rst_b) // RULE15
    rst_b && fill0 < ae_thr_reg |=> almost_empty_flag[0])
    else $error("Almost-empty flag missing");

  a_empty_clear: assert property (@(posedge clk) disable iff (!rst_b) // RULE15
    rst_b && fill0 >= ae_thr_reg |=> !almost_empty_flag[0])
    else $error("Almost-empty flag stuck high");

  a_full_set: assert property (@(posedge clk) disable iff (!rst_b) // RULE16
    rst_b && fill0 >= af_thr_reg |=> almost_full_flag[0])
    else $error("Almost-full flag missing");

  a_full_clear: assert property (@(posedge clk) disable iff (!rst_b) // RULE16
    rst_b && fill0 < af_thr_reg |=> !almost_full_flag[0])
    else $error("Almost-full flag stuck high");

  a_dual_ch0_hold: assert property (@(posedge clk) disable iff (!rst_b) // RULE3
    dual && write_enable_n[0] && write_pointer_clear_n[0] |=> $stable(wptr0))
    else $error("Channel zero write pointer moved in dual mode");

  a_thr_af_write: assert property (@(posedge clk) disable iff (!rst_b) // RULE14
    bus_commit && hit_af && (&avs_byteenable[2:0]) |=> af_thr_reg == $past(avs_writedata[23:0]))
    else $error("Almost-full threshold not written");

  a_ctrl_write: assert property (@(posedge clk) disable iff (!rst_b) // RULE17
    bus_commit && hit_ctrl && avs_byteenable[0] |=> ctrl_reg == $past(avs_writedata[2:0]))
    else $error("Control word not written");

  c_reg_write: cover property (@(posedge clk) disable iff (!rst_b) bus_commit && hit_ctrl);
  c_dual_flow: cover property (@(posedge clk) disable iff (!rst_b) dual && !write_enable_n[1] && !read_enable_n[1]);
  c_full_warn: cover property (@(posedge clk) disable iff (!rst_b) almost_full_flag[0] && !pointer_collision_flag[0]);
  c_load_read: cover property (@(posedge clk) disable iff (!rst_b) rd_load ##1 !rd_load && !read_enable_n[0]);
endmodule

/* File: verification/video_port_model.sv */
/*
  Behavioural video source and consumer facing the frame FIFO ports.
  Assumes one task at a time per side, all timing taken from the FIFO clock.
*/
module video_port_model (
  // Clock
  input wire logic clk,
  // Source side
  output logic [1:0] write_enable_n,
  output logic [1:0] write_pointer_clear_n,
  output logic write_address_load_n,
  output logic [11:0] channel_zero_data_in,
  output logic [11:0] channel_one_data_in,
  // Consumer side
  output logic [1:0] read_enable_n,
  output logic [1:0] read_pointer_clear_n,
  output logic read_address_load_n,
  input wire logic [11:0] channel_zero_data_out,
  input wire logic [11:0] channel_one_data_out
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    write_enable_n = 2'b11;
    write_pointer_clear_n = 2'b11;
    write_address_load_n = 1'b1;
    channel_zero_data_in = 12'h000;
    channel_one_data_in = 12'h000;
    read_enable_n = 2'b11;
    read_pointer_clear_n = 2'b11;
    read_address_load_n = 1'b1;
  end

  // One word per call; calls may follow each other back to back
  task automatic put(input int ch, input logic clr, input logic ld, input logic [11:0] d);
    @(posedge clk);
    write_enable_n <= ~(2'b01 << ch);
    write_pointer_clear_n <= clr ? ~(2'b01 << ch) : 2'b11;
    write_address_load_n <= ~ld;
    if (ch == 0)
      channel_zero_data_in <= d;
    else
      channel_one_data_in <= d;
  endtask

  // Released lines show the inverse of the last word, so a stale value never matches
  task automatic stop;
    @(posedge clk);
    write_enable_n <= 2'b11;
    write_pointer_clear_n <= 2'b11;
    write_address_load_n <= 1'b1;
    channel_zero_data_in <= ~channel_zero_data_in;
    channel_one_data_in <= ~channel_one_data_in;
  endtask

  // Read data is registered, so it is taken at the falling edge just after the fetch edge
  task automatic get(input int ch, input logic clr, input logic ld, output logic [11:0] q);
    @(posedge clk);
    read_enable_n <= ~(2'b01 << ch);
    read_pointer_clear_n <= clr ? ~(2'b01 << ch) : 2'b11;
    read_address_load_n <= ~ld;
    @(posedge clk);
    read_enable_n <= 2'b11;
    read_pointer_clear_n <= 2'b11;
    read_address_load_n <= 1'b1;
    @(negedge clk);
    q = (ch == 0) ? channel_zero_data_out : channel_one_data_out;
  endtask
endmodule

/* File: verification/testbench.sv */
/*
  Self-checking bench for the frame FIFO in 12-bit single-channel organisation, then in dual-channel organisation.
  Assumes the partner model drives the FIFO ports and the bench owns the register bus.
*/
`include "frame_fifo_defines.svh"

module testbench;
  import frame_fifo_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int DEPTH = 160;
  logic clk, rst_b, avs_read, avs_write, write_address_load_n, read_address_load_n, ext_port_side_select;
  logic [7:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, v;
  logic [3:0] avs_byteenable, org_select;
  logic avs_waitrequest;
  logic [1:0] write_enable_n, write_pointer_clear_n, read_enable_n, read_pointer_clear_n;
  logic [1:0] pointer_collision_flag, almost_empty_flag, almost_full_flag;
  logic [11:0] channel_zero_data_in, channel_one_data_in, channel_zero_data_out, channel_one_data_out, q;
  logic [23:0] ext_address;
  logic [11:0] pat [4] = '{12'h0a1, 12'h0b2, 12'h0c3, 12'h0d4};
  logic [11:0] trs [8] = '{12'hff0, 12'h000, 12'h000, 12'h400, 12'hff0, 12'h000, 12'h000, 12'h000};
  int error_cnt = 0;
  int compares = 0;

  video_frame_fifo_pointer_ctrl #(.CH_DEPTH(DEPTH)) dut (.clk, .rst_b, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .org_select, .write_enable_n,
    .write_pointer_clear_n, .write_address_load_n, .channel_zero_data_in, .channel_one_data_in,
    .read_enable_n, .read_pointer_clear_n, .read_address_load_n, .ext_address, .ext_port_side_select,
    .channel_zero_data_out, .channel_one_data_out, .pointer_collision_flag, .almost_empty_flag,
    .almost_full_flag);

  video_port_model far (.clk, .write_enable_n, .write_pointer_clear_n, .write_address_load_n,
    .channel_zero_data_in, .channel_one_data_in, .read_enable_n, .read_pointer_clear_n,
    .read_address_load_n, .channel_zero_data_out, .channel_one_data_out);

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk);
    avs_read <= ~wr;
    avs_write <= wr;
    avs_address <= a;
    avs_writedata <= wd;
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic rchk(input string name, input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0, v);
    check(name, exp, v);
  endtask

  // Flags trail the pointers by one cycle
  task automatic settle;
    repeat (3) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic wrap_up;
    if (error_cnt == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    repeat (6000) @(posedge clk);
    error_cnt++;
    wrap_up();
  end

  initial begin
    rst_b = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 8'h00;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    org_select = 4'h3;
    ext_address = 24'h0;
    ext_port_side_select = 1'b0;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    settle();
    check("collide", 32'h1, 32'(pointer_collision_flag[0]));
    check("almost_empty", 32'h1, 32'(almost_empty_flag[0]));
    check("almost_full", 32'h0, 32'(almost_full_flag[0]));
    rchk("ae_thr", `AE_THR_OFS, 32'(DEPTH * `AE_NUM / `THR_DEN));
    rchk("af_thr", `AF_THR_OFS, 32'(DEPTH * `AF_NUM / `THR_DEN));
    rchk("unmapped", 8'h40, 32'h0);
    for (int i = 0; i < 4; i++)
      far.put(0, i == 0, 1'b0, pat[i]);
    far.stop();
    settle();
    rchk("wptr", `WPTR_OFS, 32'h4);
    check("almost_empty", 32'h0, 32'(almost_empty_flag[0]));
    check("collide", 32'h0, 32'(pointer_collision_flag[0]));
    for (int i = 0; i < 4; i++) begin
      far.get(0, i == 0, 1'b0, q);
      check("rd_data", 32'(pat[i]), 32'(q));
    end
    settle();
    check("collide", 32'h1, 32'(pointer_collision_flag[0]));
    far.get(0, 1'b1, 1'b0, q);
    check("reread", 32'(pat[0]), 32'(q));
    bus(1'b1, `AF_THR_OFS, 32'h3, v);
    settle();
    check("almost_full", 32'h1, 32'(almost_full_flag[0]));
    bus(1'b1, `AF_THR_OFS, 32'h4, v);
    settle();
    check("almost_full", 32'h0, 32'(almost_full_flag[0]));
    bus(1'b1, `AE_THR_OFS, 32'h4, v);
    settle();
    check("almost_empty", 32'h1, 32'(almost_empty_flag[0]));
    @(posedge clk);
    ext_address <= 24'd20;
    far.put(0, 1'b0, 1'b1, 12'h5a5);
    far.put(0, 1'b0, 1'b0, 12'h6b6);
    far.stop();
    ext_port_side_select <= 1'b1;
    far.put(0, 1'b0, 1'b1, 12'h777);
    far.stop();
    settle();
    rchk("wptr", `WPTR_OFS, 32'd23);
    far.get(0, 1'b0, 1'b1, q);
    check("load_rd", 32'h5a5, 32'(q));
    far.get(0, 1'b0, 1'b0, q);
    check("seq_rd", 32'h6b6, 32'(q));
    bus(1'b1, `CTRL_OFS, 32'h1, v);
    @(posedge clk);
    ext_port_side_select <= 1'b0;
    ext_address <= {12'd2, 12'd3};
    far.put(0, 1'b0, 1'b1, 12'h2d3);
    far.stop();
    settle();
    rchk("wptr_2d", `WPTR_OFS, 32'd36);
    bus(1'b1, `CTRL_OFS, 32'h2, v);
    for (int i = 0; i < 8; i++)
      far.put(0, 1'b0, 1'b0, trs[i]);
    far.stop();
    settle();
    rchk("wptr_trs", `WPTR_OFS, 32'h0);
    bus(1'b1, `CTRL_OFS, 32'h0, v);
    for (int i = 0; i < DEPTH; i++)
      far.put(0, i == 0, 1'b0, 12'(i));
    far.stop();
    settle();
    rchk("wptr_wrap", `WPTR_OFS, 32'h0);
    // Organisation pins may only change while reset is held
    @(posedge clk);
    rst_b <= 1'b0;
    org_select <= 4'hf;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    settle();
    rchk("status", `STATUS_OFS, 32'h4f);
    far.put(1, 1'b1, 1'b1, 12'h9c0);
    far.put(1, 1'b0, 1'b0, 12'h8d1);
    far.stop();
    settle();
    rchk("wptr_dual", `WPTR_OFS, 32'h0);
    check("almost_empty", 32'h1, 32'(almost_empty_flag));
    check("collide", 32'h1, 32'(pointer_collision_flag));
    far.get(1, 1'b1, 1'b0, q);
    check("ch1_rd_data", 32'h9c0, 32'(q));
    wrap_up();
  end
endmodule
